/* bench/lsbg_chk_asserts.sv */
// Checker: bus answer, divisor and buffer-flag assertions
module lsbg_chk
   import lsbg_pkg::*;
(
   input wire logic        i_ref_clk,
   input wire logic        i_srst,
   input wire logic        i_penable,
   input wire logic        i_pwrite,
   input wire logic [7:0]  i_paddr,
   input wire logic        i_rx_load,
   input wire logic        i_tx_take,
   input wire logic [31:0] o_prdata,
   input wire logic        o_pready,
   input wire logic        o_pslverr,
   input wire logic        o_sub_tick,
   input wire logic        o_bit_tick,
   input wire logic        o_rx_full,
   input wire logic        o_tx_full
);
   default clocking @(posedge i_ref_clk);
   endclocking
   default disable iff (i_srst);
   logic rd_ans;
   assign rd_ans = o_pready && !i_pwrite;
   pready_pulse_a:
      assert property (o_pready |=> !o_pready) else $error("pready too long");
   wait_state_a:
      assert property ($rose(i_penable) |=> o_pready) else $error("late answer");
   rsvd_zero_a:
      assert property (rd_ans && i_paddr == ADDR_DIVISOR |-> o_prdata[31:28] == 4'h0)
         else $error("top bits set");
   rx_clear_a:
      assert property (rd_ans && i_paddr == ADDR_RX_DATA && !i_rx_load && !$past(i_rx_load)
         |=> !o_rx_full) else $error("rx full kept");
   shadow_keep_a:
      assert property (rd_ans && i_paddr == ADDR_RX_SHADOW && $past(o_rx_full)
         |-> o_rx_full ##1 o_rx_full) else $error("rx full lost");
   bit_sub_a:
      assert property (o_bit_tick |-> o_sub_tick) else $error("lone bit tick");
   err_answer_a:
      assert property (o_pslverr |-> o_pready && o_prdata == 32'h0) else $error("bad error");
   tx_set_a:
      assert property (o_pready && i_pwrite && i_paddr == ADDR_TX_DATA && !$past(i_tx_take)
         |-> o_tx_full) else $error("tx full not set");
endmodule // lsbg_chk

bind lsbg_top lsbg_chk u_chk (.i_ref_clk, .i_srst, .i_penable, .i_pwrite, .i_paddr,
   .i_rx_load, .i_tx_take, .o_prdata, .o_pready, .o_pslverr, .o_sub_tick, .o_bit_tick,
   .o_rx_full, .o_tx_full);

/* bench/lsbg_peer.sv */
// Serial peer model: delivers received bytes and drains the transmit buffer
module lsbg_peer (
   input  wire logic       i_clk,
   input  wire logic       i_send,
   input  wire logic [7:0] i_byte,
   input  wire logic       i_drain,
   input  wire logic       i_tx_full,
   output logic            o_rx_load,
   output logic [7:0]      o_rx_byte,
   output logic            o_tx_take
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       load_q = 1'b0;
   logic       take_q = 1'b0;
   logic [7:0] last   = 8'h00;
   // Drain low models a slow peer; byte lines invert outside a delivery
   always @(posedge i_clk) begin
      load_q <= i_send;
      take_q <= i_drain && i_tx_full;
      if (i_send) last <= i_byte;
   end
   assign o_rx_load = load_q;
   assign o_rx_byte = load_q ? last : ~last;
   assign o_tx_take = take_q;
endmodule // lsbg_peer

/* bench/lsbg_top_tb.sv */
// Testbench: register, divider and data-buffer checks
module lsbg_top_tb
   import lsbg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        i_ref_clk, i_srst, i_psel, i_penable, i_pwrite, i_rx_load, i_tx_take;
   logic        o_pready, o_pslverr, o_sub_tick, o_bit_tick, o_rx_full, o_tx_full;
   logic        send, drain, err;
   logic [7:0]  i_paddr, i_rx_byte, o_tx_byte, sbyte;
   logic [31:0] i_pwdata, o_prdata, rd;
   logic [31:0] dv [3] = '{32'h0400_000f, 32'h0f00_0000, 32'h0000_0003};
   int          mismatches = 0;
   int          samples_checked = 0;
   int          per;
   int          subs;
   lsbg_top dut (.i_ref_clk, .i_srst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
      .i_rx_load, .i_rx_byte, .i_tx_take, .o_prdata, .o_pready, .o_pslverr, .o_sub_tick,
      .o_bit_tick, .o_rx_full, .o_tx_full, .o_tx_byte);
   lsbg_peer peer (.i_clk(i_ref_clk), .i_send(send), .i_byte(sbyte), .i_drain(drain),
      .i_tx_full(o_tx_full), .o_rx_load(i_rx_load), .o_rx_byte(i_rx_byte),
      .o_tx_take(i_tx_take));
   // ****************************************************************
   // Tasks
   // ****************************************************************
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      samples_checked++;
      if (got !== ex) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_ref_clk);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_ref_clk);
      i_penable <= 1'b1;
      // The wait ends when o_pready is seen; only the watchdog ends a wait that never sees it
      do begin
         @(posedge i_ref_clk);
      end while (o_pready !== 1'b1);
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask
   // Clocks from one bit tick to the next; the first span after a write may be short
   task automatic period();
      per = 0;
      while (o_bit_tick !== 1'b1 && per < 900) begin
         @(posedge i_ref_clk);
         per++;
      end
      per = 0;
      subs = 0;
      do begin
         @(posedge i_ref_clk);
         per++;
         if (o_sub_tick === 1'b1) subs++;
      end while (o_bit_tick !== 1'b1 && per < 900);
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ****************************************************************
   // Stimulus
   // ****************************************************************
   initial begin
      i_ref_clk = 1'b0;
      forever #4 i_ref_clk = ~i_ref_clk;
   end
   initial begin
      repeat (20000) @(posedge i_ref_clk);
      mismatches++;
      complete_run();
   end
   initial begin
      {i_srst, i_psel, i_penable, i_pwrite, send, drain} = 6'h20;
      i_paddr = 8'h00;
      i_pwdata = 32'h0;
      sbyte = 8'h00;
      repeat (6) @(posedge i_ref_clk);
      i_srst <= 1'b0;
      apb(1'b0, ADDR_DIVISOR, 32'h0);
      chk("divisor reset", 32'h0, rd);
      apb(1'b1, ADDR_DIVISOR, 32'hffff_ffff);
      apb(1'b0, ADDR_DIVISOR, 32'h0);
      chk("divisor fields", 32'h0fff_ffff, rd);
      for (int k = 0; k < 3; k++) begin
         apb(1'b1, ADDR_DIVISOR, dv[k]);
         period();
         period();
         chk("bit period", 16 * (dv[k][23:0] + 1) + dv[k][27:24], 32'(per));
         chk("sub ticks", 32'h10, 32'(subs));
      end
      apb(1'b0, 8'h18, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      @(posedge i_ref_clk);
      send <= 1'b1;
      sbyte <= 8'ha5;
      @(posedge i_ref_clk);
      send <= 1'b0;
      apb(1'b0, ADDR_RX_SHADOW, 32'h0);
      chk("shadow data", 32'ha5, rd);
      apb(1'b1, ADDR_RX_DATA, 32'h77);
      apb(1'b0, ADDR_RX_DATA, 32'h0);
      chk("rx data", 32'ha5, rd);
      apb(1'b1, ADDR_TX_DATA, 32'h13c);
      chk("tx byte", 32'h3c, {24'h0, o_tx_byte});
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("status", 32'h2, rd);
      drain <= 1'b1;
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("drained", 32'h0, rd);
      apb(1'b0, ADDR_TX_DATA, 32'h0);
      chk("tx readback", 32'h3c, rd);
      apb(1'b1, ADDR_RX_LOAD, 32'h1c3);
      apb(1'b0, ADDR_RX_SHADOW, 32'h0);
      chk("loaded shadow", 32'hc3, rd);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("shadow keeps full", 32'h1, rd);
      complete_run();
   end
endmodule // lsbg_top_tb

/* verilog/lsbg_frac_divider.sv */
// Fractional divider: one tick per sixteenth of a bit, with a bit-clock strobe
module lsbg_frac_divider
   import lsbg_pkg::*;
(
   input  wire logic          i_ref_clk,
   input  wire logic          i_srst,
   input  wire lsbg_divisor_t i_div,
   output logic              o_sub_tick,
   output logic              o_bit_tick
);

   // One spare bit so a stretched maximum prescale does not wrap to zero
   logic [24:0] cnt_reg;
   logic [24:0] cnt_next;
   logic [3:0]  sub_reg;
   logic [3:0]  sub_next;
   logic        sub_tick_reg;
   logic        sub_tick_next;
   logic        bit_tick_reg;
   logic        bit_tick_next;
   logic        stretch;
   logic [24:0] limit;

   // ****************************************************************
   // Divider
   // ****************************************************************
   // (R02) fraction stretches some sixteenths
   // Of every sixteen sub-periods, frac of them last one extra clock, so the
   // average sub-period is (P + 1 + M/16) clocks.
   // (R11) async rate formula
   always_comb begin
      stretch       = (sub_reg < i_div.frac);
      // (R04) integer prescaler sets length
      limit         = stretch ? {1'b0, i_div.prescale} + 25'h1 : {1'b0, i_div.prescale};
      cnt_next      = cnt_reg + 25'h1;
      sub_next      = sub_reg;
      sub_tick_next = 1'b0;
      bit_tick_next = 1'b0;
      // (R05) derived from input clock only
      if (cnt_reg >= limit) begin
         cnt_next      = 25'h0;
         sub_next      = sub_reg + 4'h1;
         sub_tick_next = 1'b1;
         // (R03) sixteen steps per integer value
         bit_tick_next = (sub_reg == SUB_LAST);
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         cnt_reg      <= 25'h0;
         sub_reg      <= 4'h0;
         sub_tick_reg <= 1'b0;
         bit_tick_reg <= 1'b0;
      end else begin
         cnt_reg      <= cnt_next;
         sub_reg      <= sub_next;
         sub_tick_reg <= sub_tick_next;
         bit_tick_reg <= bit_tick_next;
      end
   end

   assign o_sub_tick = sub_tick_reg;
   assign o_bit_tick = bit_tick_reg;

endmodule // lsbg_frac_divider

/* verilog/lsbg_pkg.sv */
// Package: register map, field layout and constants of the bit-rate generator
//
// Behaviour
// (R01) Divisor bits 31..28 read zero; writes to them are ignored.
// (R02) Fractional field in bits 27..24 refines rate in both serial modes.
// (R03) Fraction gives fifteen intermediate rates between adjacent integer settings.
// (R04) Integer prescaler in bits 23..0 selects the bit rate in both modes.
// (R05) Bit clock derives only from input clock, prescaler and fraction.
// (R06) 30 MHz, integer 15, fraction 4 gives about 115385 bit/s.
// (R07) Three separately addressable locations hold transmit and receive data.
// (R08) Receive shadow view returns same storage as receive data buffer.
// (R09) Reading the shadow view leaves the receive-full flag unchanged.
// (R10) Reading the receive data buffer clears the receive-full flag.
// (R11) Async rate is clock / (16 * (integer + 1 + fraction/16)).
package lsbg_pkg;

   // ****************************************************************
   // Register map (byte addresses)
   // ****************************************************************
   localparam logic [7:0]  ADDR_DIVISOR   = 8'h00;
   localparam logic [7:0]  ADDR_RX_SHADOW = 8'h04;
   localparam logic [7:0]  ADDR_RX_DATA   = 8'h08;
   localparam logic [7:0]  ADDR_TX_DATA   = 8'h0c;
   localparam logic [7:0]  ADDR_STATUS    = 8'h10;
   localparam logic [7:0]  ADDR_RX_LOAD   = 8'h14;

   // ****************************************************************
   // Field layout and reset values
   // ****************************************************************
   localparam int          FRAC_MSB       = 27;
   localparam int          FRAC_LSB       = 24;
   localparam int          INT_MSB        = 23;
   localparam int          INT_LSB        = 0;
   localparam int          STAT_RX_FULL   = 0;
   localparam int          STAT_TX_FULL   = 1;
   localparam logic [31:0] DIVISOR_RESET  = 32'h0000_0000;
   localparam logic [7:0]  DATA_RESET     = 8'h00;
   localparam logic [3:0]  SUB_LAST       = 4'hf;

   typedef struct packed {
      logic [3:0]  frac;
      logic [23:0] prescale;
   } lsbg_divisor_t;

   typedef struct packed {
      logic        sel;
      logic        enable;
      logic        write;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } lsbg_apb_req_t;

endpackage : lsbg_pkg

/* verilog/lsbg_top.sv */
// Bit-rate generator top: APB register file, data buffers and divider
module lsbg_top
   import lsbg_pkg::*;
(
   input  wire logic        i_ref_clk,
   input  wire logic        i_srst,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [7:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   input  wire logic        i_rx_load,
   input  wire logic [7:0]  i_rx_byte,
   input  wire logic        i_tx_take,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   output logic             o_sub_tick,
   output logic             o_bit_tick,
   output logic             o_rx_full,
   output logic             o_tx_full,
   output logic [7:0]       o_tx_byte
);

   lsbg_apb_req_t req;
   lsbg_divisor_t div_reg;
   lsbg_divisor_t div_next;
   logic [7:0]    rx_reg;
   logic [7:0]    rx_next;
   logic [7:0]    tx_reg;
   logic [7:0]    tx_next;
   logic          rx_full_reg;
   logic          rx_full_next;
   logic          tx_full_reg;
   logic          tx_full_next;
   logic [31:0]   prdata_reg;
   logic [31:0]   prdata_next;
   logic          pready_reg;
   logic          pready_next;
   logic          pslverr_reg;
   logic          pslverr_next;
   logic          access;
   logic          wr;
   logic          rd;
   logic          mapped;

   assign req = '{sel: i_psel, enable: i_penable, write: i_pwrite,
                  addr: i_paddr, wdata: i_pwdata};

   // ****************************************************************
   // APB slave: one wait state, answer in the second access cycle
   // ****************************************************************
   always_comb begin
      access = req.sel && req.enable && !pready_reg;
      wr     = access && req.write;
      rd     = access && !req.write;
      case (req.addr)
         ADDR_DIVISOR, ADDR_RX_SHADOW, ADDR_RX_DATA,
         ADDR_TX_DATA, ADDR_STATUS, ADDR_RX_LOAD: mapped = 1'b1;
         default:                                  mapped = 1'b0;
      endcase
   end

   always_comb begin
      div_next     = div_reg;
      rx_next      = rx_reg;
      tx_next      = tx_reg;
      rx_full_next = rx_full_reg;
      tx_full_next = tx_full_reg;
      prdata_next  = 32'h0;
      pready_next  = access;
      pslverr_next = access && !mapped;
      if (tx_full_reg && i_tx_take) begin
         tx_full_next = 1'b0;
      end
      if (rd) begin
         case (req.addr)
            // (R01) top nibble reads zero
            ADDR_DIVISOR:   prdata_next = {4'h0, div_reg};
            // (R08) same storage as rx buffer
            // (R09) no flag side effect
            ADDR_RX_SHADOW: prdata_next = {24'h0, rx_reg};
            ADDR_RX_DATA: begin
               prdata_next  = {24'h0, rx_reg};
               // (R10) read clears full flag
               rx_full_next = 1'b0;
            end
            ADDR_TX_DATA:   prdata_next = {24'h0, tx_reg};
            ADDR_STATUS:    prdata_next = {30'h0, tx_full_reg, rx_full_reg};
            default:        prdata_next = 32'h0;
         endcase
      end
      if (wr) begin
         case (req.addr)
            // (R01) top nibble write ignored
            ADDR_DIVISOR: div_next = req.wdata[FRAC_MSB:INT_LSB];
            ADDR_TX_DATA: begin
               tx_next      = req.wdata[7:0];
               tx_full_next = 1'b1;
            end
            // Software load stands in for a received frame
            ADDR_RX_LOAD: begin
               rx_next      = req.wdata[7:0];
               rx_full_next = 1'b1;
            end
            default: ;
         endcase
      end
      // (R07) separate receive location loaded by receiver
      // A frame arriving in the read cycle wins over the clear
      if (i_rx_load) begin
         rx_next      = i_rx_byte;
         rx_full_next = 1'b1;
      end
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         div_reg     <= DIVISOR_RESET[FRAC_MSB:INT_LSB];
         rx_reg      <= DATA_RESET;
         tx_reg      <= DATA_RESET;
         rx_full_reg <= 1'b0;
         tx_full_reg <= 1'b0;
         prdata_reg  <= 32'h0;
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         div_reg     <= div_next;
         rx_reg      <= rx_next;
         tx_reg      <= tx_next;
         rx_full_reg <= rx_full_next;
         tx_full_reg <= tx_full_next;
         prdata_reg  <= prdata_next;
         pready_reg  <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   // ****************************************************************
   // Bit-rate divider
   // ****************************************************************
   // (R06) divisor 15/4 at 30 MHz gives 115385
   lsbg_frac_divider u_div (
      .i_ref_clk  (i_ref_clk),
      .i_srst     (i_srst),
      .i_div      (div_reg),
      .o_sub_tick (o_sub_tick),
      .o_bit_tick (o_bit_tick)
   );

   assign o_prdata  = prdata_reg;
   assign o_pready  = pready_reg;
   assign o_pslverr = pslverr_reg;
   assign o_rx_full = rx_full_reg;
   assign o_tx_full = tx_full_reg;
   assign o_tx_byte = tx_reg;

endmodule // lsbg_top
